// ===== rtl/dcl_dac_control.sv
`default_nettype none
module dcl_dac_control
  import dcl_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic [DCL_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic                  i_standby,
  input  wire logic                  i_powerdown,
  input  wire logic                  i_debug_halt,
  output logic      [7:0]            o_code,
  output logic                       o_convert_start,
  output logic                       o_core_on,
  output logic                       o_buffer_on,
  output logic                       o_internal_valid
);
  import dcl_pkg::*;

  logic                  wr_pulse;
  logic [DCL_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic [31:0]           rd_value;
  logic [7:0]            ctrl_reg;
  logic [7:0]            ctrl_next;
  logic [7:0]            code_reg;
  logic [7:0]            code_next;
  logic                  start_reg;
  logic                  start_next;
  logic                  core_on;
  logic                  buffer_on;
  logic                  restart;
  logic                  stand;
  logic                  pdown;
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  pd1_reg;
  logic                  pd2_reg;

  dcl_avmm_slave u_bus (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_address     (i_avs_address),
    .i_read        (i_avs_read),
    .i_write       (i_avs_write),
    .i_writedata   (i_avs_writedata),
    .i_byteenable  (i_avs_byteenable),
    .i_rd_value    (rd_value),
    .o_readdata    (o_avs_readdata),
    .o_waitrequest (o_avs_waitrequest),
    .o_wr_pulse    (wr_pulse),
    .o_wr_addr     (wr_addr),
    .o_wr_data     (wr_data)
  );

  // sleep requests come from the power manager pins
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      pd1_reg   <= 1'b0;
      pd2_reg   <= 1'b0;
    end else begin
      sync1_reg <= i_standby;
      sync2_reg <= sync1_reg;
      pd1_reg   <= i_powerdown;
      pd2_reg   <= pd1_reg;
    end
  end
  assign stand = sync2_reg;
  assign pdown = pd2_reg;

  dcl_power_gate u_gate (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_enable    (ctrl_reg[DCL_EN_BIT]),
    .i_pin_on    (ctrl_reg[DCL_PIN_BIT]),
    .i_keep      (ctrl_reg[DCL_KEEP_BIT]),
    .i_standby   (stand),
    .i_powerdown (pdown),
    .o_core_on   (core_on),
    .o_buffer_on (buffer_on),
    .o_restart   (restart)
  );

  function automatic logic [31:0] dcl_read_mux(input logic [DCL_ADDR_W-1:0] a, input logic [7:0] c,
                                               input logic [7:0] d, input logic co, input logic bo);
    logic [31:0] v;
    v = DCL_UNMAPPED_RD;
    case (a)
      DCL_CTRL_ADDR: v = {24'h000000, c};
      DCL_CODE_ADDR: v = {24'h000000, d};
      DCL_STAT_ADDR: v = {30'h0000_0000, bo, co};
      default:       v = DCL_UNMAPPED_RD;
    endcase
    return v;
  endfunction : dcl_read_mux

  assign rd_value = dcl_read_mux(i_avs_address, ctrl_reg, code_reg, core_on, buffer_on);

  // debug halt is deliberately not an input to any next-state term
  always_comb begin
    ctrl_next  = ctrl_reg;
    code_next  = code_reg;
    start_next = 1'b0;
    if (wr_pulse && wr_addr == DCL_CTRL_ADDR) begin
      ctrl_next = wr_data & DCL_CTRL_MASK;
      if (wr_data[DCL_EN_BIT] && !ctrl_reg[DCL_EN_BIT]) begin
        start_next = !(pdown || (stand && !wr_data[DCL_KEEP_BIT]));
      end
    end
    if (wr_pulse && wr_addr == DCL_CODE_ADDR) begin
      code_next  = wr_data;
      start_next = core_on;
    end
    if (restart) begin
      start_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl_reg  <= DCL_CTRL_RST;
      code_reg  <= DCL_CODE_RST;
      start_reg <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      code_reg  <= code_next;
      start_reg <= start_next;
    end
  end

  assign o_code           = code_reg;
  assign o_convert_start  = start_reg;
  assign o_core_on        = core_on;
  assign o_buffer_on      = buffer_on;
  assign o_internal_valid = core_on;

  halt_ignored_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_debug_halt && !wr_pulse |=> ctrl_reg == $past(ctrl_reg) && code_reg == $past(code_reg))
    else $error("registers changed during debug halt");

  sequence code_write_s;
    wr_pulse && wr_addr == DCL_CODE_ADDR;
  endsequence
  sequence enable_write_s;
    wr_pulse && wr_addr == DCL_CTRL_ADDR && wr_data[DCL_EN_BIT] && !ctrl_reg[DCL_EN_BIT];
  endsequence

  start_on_data_a: assert property (@(posedge i_clock) disable iff (i_srst)
    code_write_s and core_on |=> o_convert_start && o_code == $past(wr_data))
    else $error("data write while running did not start conversion");
  no_start_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
    code_write_s and !ctrl_reg[DCL_EN_BIT] and !restart |=> !o_convert_start)
    else $error("conversion started while disabled");
  start_on_enable_a: assert property (@(posedge i_clock) disable iff (i_srst)
    enable_write_s and !pdown and !stand |=> o_convert_start)
    else $error("enable write did not start conversion");
  enable_bit_a: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_pulse && wr_addr == DCL_CTRL_ADDR |=> ctrl_reg[DCL_EN_BIT] == $past(wr_data[DCL_EN_BIT]))
    else $error("enable bit not taken");
  buffer_gate_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_buffer_on |-> ctrl_reg[DCL_PIN_BIT] && o_core_on)
    else $error("buffer on without its enable");
  keep_running_a: assert property (@(posedge i_clock) disable iff (i_srst)
    stand && !pdown && ctrl_reg[DCL_KEEP_BIT] && ctrl_reg[DCL_EN_BIT] |-> o_core_on)
    else $error("converter stopped in standby with keep bit");
  standby_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
    stand && !ctrl_reg[DCL_KEEP_BIT] |-> !o_core_on && !o_buffer_on)
    else $error("converter running in standby");
  wake_restart_a: assert property (@(posedge i_clock) disable iff (i_srst)
    $fell(stand) && !pdown && ctrl_reg[DCL_EN_BIT] && !ctrl_reg[DCL_KEEP_BIT] |=> o_convert_start)
    else $error("no restart after standby exit");
  powerdown_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
    pdown |-> !o_core_on && !o_buffer_on)
    else $error("converter on in power-down");
  internal_path_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_internal_valid == o_core_on)
    else $error("internal path mismatch");
  reserved_zero_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (ctrl_reg & ~DCL_CTRL_MASK) == 8'h00)
    else $error("reserved control bits set");
endmodule : dcl_dac_control
`default_nettype wire

// ===== rtl/dcl_pkg.sv
// Notes on behaviour
// - enabled: data write starts conversion at once
// - disabled: data stored, enable write starts
// - control bit 0 enables or disables converter
// - control bit 6 turns pin buffer on
// - standby keep-running bit keeps block alive
// - standby without keep bit stops everything
// - standby exit restores converter, buffer if set
// - power-down always stops converter and buffer
// - internal paths fed while converter core is on
// - internal paths ignore pin buffer enable
// - data register holds eight-bit linear code
// - debug halt changes nothing
`default_nettype none
package dcl_pkg;
  localparam logic [31:0] DCL_CTRL_IDX     = 32'h0000_0000;
  localparam logic [31:0] DCL_CODE_IDX     = 32'h0000_0001;
  localparam int          DCL_ADDR_W       = 4;
  localparam logic [3:0]  DCL_CTRL_ADDR    = 4'h0;
  localparam logic [3:0]  DCL_CODE_ADDR    = 4'h4;
  localparam logic [3:0]  DCL_STAT_ADDR    = 4'h8;
  localparam int          DCL_EN_BIT       = 0;
  localparam int          DCL_PIN_BIT      = 6;
  localparam int          DCL_KEEP_BIT     = 7;
  localparam logic [7:0]  DCL_CTRL_MASK    = 8'hC1;
  localparam logic [7:0]  DCL_CTRL_RST     = 8'h00;
  localparam logic [7:0]  DCL_CODE_RST     = 8'h00;
  localparam logic [31:0] DCL_UNMAPPED_RD  = 32'h0000_0000;
  typedef enum logic [1:0] {
    DCL_AWAKE,
    DCL_STANDBY,
    DCL_POWERDOWN
  } dcl_sleep_t;
endpackage : dcl_pkg
`default_nettype wire

// ===== rtl/dcl_avmm_slave.sv
`default_nettype none
module dcl_avmm_slave
  import dcl_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic [DCL_ADDR_W-1:0] i_address,
  input  wire logic                  i_read,
  input  wire logic                  i_write,
  input  wire logic [31:0]           i_writedata,
  input  wire logic [3:0]            i_byteenable,
  input  wire logic [31:0]           i_rd_value,
  output logic      [31:0]           o_readdata,
  output logic                       o_waitrequest,
  output logic                       o_wr_pulse,
  output logic      [DCL_ADDR_W-1:0] o_wr_addr,
  output logic      [7:0]            o_wr_data
);
  import dcl_pkg::*;
  // one wait cycle per access, answer on second edge
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  always_comb begin
    ack_next   = (i_read || i_write) && !ack_reg;
    rdata_next = rdata_reg;
    if ((i_read || i_write) && !ack_reg) begin
      rdata_next = i_read ? i_rd_value : rdata_reg;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
  assign o_waitrequest = (i_read || i_write) && !ack_reg;
  assign o_readdata    = rdata_reg;
  assign o_wr_pulse    = i_write && ack_reg && i_byteenable[0];
  assign o_wr_addr     = i_address;
  assign o_wr_data     = i_writedata[7:0];
endmodule : dcl_avmm_slave
`default_nettype wire

// ===== rtl/dcl_power_gate.sv
`default_nettype none
module dcl_power_gate
  import dcl_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_srst,
  input  wire logic i_enable,
  input  wire logic i_pin_on,
  input  wire logic i_keep,
  input  wire logic i_standby,
  input  wire logic i_powerdown,
  output logic      o_core_on,
  output logic      o_buffer_on,
  output logic      o_restart
);
  import dcl_pkg::*;
  logic sleep_off;
  logic off_reg;
  logic off_next;
  assign sleep_off = i_powerdown || (i_standby && !i_keep);
  always_comb begin
    off_next = sleep_off;
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      off_reg <= 1'b0;
    end else begin
      off_reg <= off_next;
    end
  end
  assign o_core_on   = i_enable && !sleep_off;
  assign o_buffer_on = i_enable && i_pin_on && !sleep_off;
  assign o_restart   = off_reg && !sleep_off && i_enable;
endmodule : dcl_power_gate
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcl_pkg::*;
  logic                  i_clock   = 1'b0;
  logic                  srst      = 1'b1;
  logic [DCL_ADDR_W-1:0] address   = '0;
  logic                  rd        = 1'b0;
  logic                  wr        = 1'b0;
  logic [31:0]           wdata     = '0;
  logic [3:0]            be        = '0;
  logic                  standby   = 1'b0;
  logic                  powerdown = 1'b0;
  logic                  halt      = 1'b0;
  logic [31:0]           readdata;
  logic                  waitreq;
  logic [7:0]            code;
  logic                  start;
  logic                  core_on;
  logic                  buf_on;
  logic                  int_valid;
  logic [31:0]           q;
  logic [31:0]           v;
  logic [31:0]           rng       = 32'h0000_0E00;
  logic [7:0]            cv [4]    = '{8'h41, 8'hC1, 8'h01, 8'h81};
  logic [1:0]            g;
  logic                  seen;
  int                    miscompares;
  int                    samples_checked;
  int                    cyc;

  always #25 i_clock = ~i_clock;

  dcl_dac_control dut_u (
    .i_clock(i_clock), .i_srst(srst), .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .i_standby(standby), .i_powerdown(powerdown), .i_debug_halt(halt),
    .o_code(code), .o_convert_start(start), .o_core_on(core_on), .o_buffer_on(buf_on),
    .o_internal_valid(int_valid)
  );

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  function automatic logic [31:0] ctrl_exp(input logic [7:0] w);
    return {24'h00_0000, w & DCL_CTRL_MASK};
  endfunction : ctrl_exp

  // expected {core, buffer} for a control value and sleep state
  function automatic logic [1:0] gate_exp(input logic [7:0] c, input logic sb, input logic pd);
    logic on;
    on = c[DCL_EN_BIT] && !pd && !(sb && !c[DCL_KEEP_BIT]);
    return {on, on && c[DCL_PIN_BIT]};
  endfunction : gate_exp

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : chk

  // one bus access; held until waitrequest seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] r);
    @(posedge i_clock);
    address <= a;
    rd      <= !w;
    wr      <= w;
    wdata   <= {24'h00_0000, d};
    be      <= b;
    do @(posedge i_clock); while (waitreq !== 1'b0);
    r = readdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge i_clock);
    srst <= 1'b0;
    bus(DCL_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
    chk(q, 32'h0000_0000);
    bus(DCL_CODE_ADDR, 1'b0, 8'h00, 4'hF, q);
    chk(q, 32'h0000_0000);
    chk({core_on, buf_on, int_valid, start, code}, 32'h0000_0000);
    $display("reset test done");
    v = xs();
    bus(DCL_CODE_ADDR, 1'b1, v[7:0], 4'hF, q);
    @(negedge i_clock);
    chk(start, 1'b0);
    chk(code, v[7:0]);
    bus(DCL_CTRL_ADDR, 1'b1, 8'h01, 4'h1, q);
    @(negedge i_clock);
    chk(start, 1'b1);
    chk({core_on, int_valid, buf_on}, 3'b110);
    $display("deferred start test done");
    for (int i = 0; i < 10; i++) begin
      v = xs();
      v[7:0] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : v[7:0];
      halt <= v[8];
      bus(DCL_CODE_ADDR, 1'b1, v[7:0], 4'h1, q);
      @(negedge i_clock);
      chk(start, 1'b1);
      bus(DCL_CODE_ADDR, 1'b0, 8'h00, 4'hF, q);
      chk(q, {24'h00_0000, v[7:0]});
    end
    $display("enabled write test done");
    bus(DCL_CTRL_ADDR, 1'b1, 8'hFF, 4'h1, q);
    bus(DCL_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
    chk(q, ctrl_exp(8'hFF));
    chk({buf_on, int_valid}, 2'b11);
    bus(DCL_CTRL_ADDR, 1'b1, 8'h00, 4'h0, q);
    bus(DCL_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
    chk(q, ctrl_exp(8'hFF));
    bus(4'hC, 1'b1, 8'h5A, 4'hF, q);
    bus(4'hC, 1'b0, 8'h00, 4'hF, q);
    chk(q, DCL_UNMAPPED_RD);
    bus(DCL_STAT_ADDR, 1'b0, 8'h00, 4'hF, q);
    chk(q, 32'h0000_0003);
    $display("control mask test done");
    for (int i = 0; i < 4; i++) begin
      bus(DCL_CTRL_ADDR, 1'b1, cv[i], 4'h1, q);
      for (int m = 0; m < 2; m++) begin
        @(posedge i_clock);
        standby   <= (m == 0);
        powerdown <= (m == 1);
        repeat (4) @(negedge i_clock);
        g = gate_exp(cv[i], m == 0, m == 1);
        chk({core_on, buf_on, int_valid}, {g, g[1]});
        @(posedge i_clock);
        standby   <= 1'b0;
        powerdown <= 1'b0;
        seen = 1'b0;
        repeat (6) @(negedge i_clock) seen |= start;
        chk(seen, !g[1]);
        chk({core_on, buf_on}, gate_exp(cv[i], 1'b0, 1'b0));
      end
    end
    $display("sleep test done");
    bus(DCL_CTRL_ADDR, 1'b1, 8'h00, 4'h1, q);
    @(negedge i_clock);
    chk({core_on, buf_on, int_valid, start}, 4'h0);
    $display("disable test done");
    test_done();
  end
endmodule : tb
`default_nettype wire
